// ---- bench/dtf_cmd_engine_test.sv ----
// self-checking testbench of the command engine against the drive model
`timescale 1ns/1ps
module dtf_cmd_engine_test;
  import dtf_pkg::*;
  localparam int SPT = 8;
  logic mclk = 1'b0, rst_n = 1'b0, cmd_valid = 1'b0, crc_mode = 1'b0, ecc_ok = 1'b0, seek_fail = 1'b0;
  logic [1:0] rd_errs = 2'b00;
  dtf_cmd_t cmd_block = '0;
  logic cmd_ready, cmd_done, rd_sector_valid, drv_seek_req, drv_recal_req, drv_done, drv_fail;
  logic drv_id_req, drv_id_valid, drv_id_crc_err, drv_wr_req, drv_fill_buf, drv_wr_ack;
  logic drv_rd_req, drv_rd_done, drv_rd_err, drv_rd_ecc_fix;
  logic [5:0] cmd_err_code;
  logic [1:0] drive_select_field;
  logic [19:0] cmd_err_lsa, rd_sector_lsa, drv_track, drv_rd_lsa, first_lsa;
  logic [7:0] drv_fill;
  dtf_id_t drv_id, drv_wr_id;
  int err_count = 0, n_compared = 0, n_rd, rc0, n_recal;
  always #5 mclk = ~mclk;
  dtf_cmd_engine #(.SECT_BITS(3), .RETRY_MAX(2)) u_dut (.mclk, .rst_n, .cmd_valid, .cmd_block, .cmd_ready,
    .cmd_done, .cmd_err_code, .cmd_err_lsa, .drive_select_field, .rd_sector_valid, .rd_sector_lsa,
    .drv_seek_req, .drv_recal_req, .drv_track, .drv_done, .drv_fail, .drv_id_req, .drv_id_valid,
    .drv_id_crc_err, .drv_id, .drv_wr_req, .drv_wr_id, .drv_fill, .drv_fill_buf, .drv_wr_ack,
    .drv_rd_req, .drv_rd_lsa, .drv_rd_done, .drv_rd_err, .drv_rd_ecc_fix);
  dtf_drive_model #(.SPT(SPT)) u_drv (.mclk, .rst_n, .drv_seek_req, .drv_recal_req, .drv_track,
    .drv_id_req, .drv_wr_req, .drv_wr_id, .drv_rd_req, .crc_mode, .rd_errs, .ecc_ok, .seek_fail, .drv_done,
    .drv_fail, .drv_id_valid, .drv_id_crc_err, .drv_id, .drv_wr_ack, .drv_rd_done, .drv_rd_err,
    .drv_rd_ecc_fix, .n_recal);
  // verdict and end of run
  task automatic close_out;
    if (err_count == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out
  // compare one value
  task automatic chk(input string nm, input logic [19:0] exp, input logic [19:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // offer one command block, then wait for completion, counting read sectors
  task automatic run(input logic [7:0] op, c1, lo, arg, opt);
    int t;
    rc0 = n_recal;
    n_rd = 0;
    @(posedge mclk);
    #1 cmd_valid = 1'b1;
    cmd_block = {op, c1, 8'h00, lo, arg, opt};
    for (t = 0; t < 20000 && cmd_ready !== 1'b1; t++) @(negedge mclk);
    if (t == 20000) begin
      err_count++;
      close_out();
    end
    @(posedge mclk);
    #1 cmd_valid = 1'b0;
    for (t = 0; t < 20000; t++) begin
      @(negedge mclk);
      if (rd_sector_valid === 1'b1 && n_rd == 0) first_lsa = rd_sector_lsa;
      if (rd_sector_valid === 1'b1) n_rd++;
      if (cmd_done === 1'b1) break;
    end
    if (t == 20000) begin
      err_count++;
      close_out();
    end
  endtask : run
  // expected sector per slot for an interleave, compared with what the drive holds
  task automatic chk_ilv(input int ilv);
    logic [7:0] tb [SPT];
    bit used [SPT];
    int p;
    p = 0;
    for (int s = 0; s < SPT; s++) begin
      if (s > 0) p = (p + ilv) % SPT;
      while (used[p]) p = (p + 1) % SPT;
      used[p] = 1;
      tb[p] = 8'(s);
    end
    for (int k = 0; k < SPT; k++) chk("slot", {12'h000, tb[k]}, {12'h000, u_drv.mem[k]});
  endtask : chk_ilv
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (6) @(posedge mclk);
    #1 rst_n = 1'b1;
    // unformatted drive, mid-track address, buffer pattern
    run(OP_FMT, 8'h40, 8'h2B, 8'h03, 8'h20);
    chk("fmt err", 20'h0, 20'(cmd_err_code));
    chk("recal", 20'h1, 20'(n_recal - rc0));
    chk("end lsa", 20'h30, cmd_err_lsa);
    chk("track", 20'h5, u_drv.fmt_trk_q);
    chk("seek trk", 20'h5, drv_track);
    chk("buf", 20'h1, 20'(drv_fill_buf));
    chk("drive", 20'h2, 20'(drive_select_field));
    chk_ilv(3);
    // check with stray fixed-zero bits set
    run(OP_CHECK, 8'hC0, 8'h2B, 8'hE3, 8'h9F);
    chk("chk err", 20'h0, 20'(cmd_err_code));
    chk("chk recal", 20'h0, 20'(n_recal - rc0));
    run(OP_CHECK, 8'h40, 8'h2B, 8'h02, 8'h80);
    chk("ilv err", 20'h12, 20'(cmd_err_code));
    crc_mode = 1'b1;
    run(OP_CHECK, 8'h40, 8'h2B, 8'h03, 8'h80);
    chk("id err", 20'h11, 20'(cmd_err_code));
    crc_mode = 1'b0;
    // bad track format on a formatted track verifies without recalibration
    run(OP_FMT_BAD, 8'h40, 8'h2B, 8'h03, 8'h00);
    chk("bad recal", 20'h0, 20'(n_recal - rc0));
    chk("fill", 20'h6C, 20'(drv_fill));
    chk("no buf", 20'h0, 20'(drv_fill_buf));
    chk("flag", 20'h2, 20'(u_drv.fmt_flags_q));
    run(OP_READ, 8'h40, 8'h2B, 8'h01, 8'h00);
    chk("refused", 20'h19, 20'(cmd_err_code));
    run(OP_FMT, 8'h40, 8'h2B, 8'h03, 8'h00);
    chk("cleared", 20'h0, 20'(u_drv.fmt_flags_q));
    // reads of two and of 256 sectors
    run(OP_READ, 8'h40, 8'h2B, 8'h02, 8'h00);
    chk("rd n", 20'd2, 20'(n_rd));
    chk("rd lsa", 20'h2B, first_lsa);
    chk("rd last", 20'h2C, rd_sector_lsa);
    chk("rd req lsa", 20'h2C, drv_rd_lsa);
    run(OP_READ, 8'h40, 8'h2B, 8'h00, 8'h00);
    chk("rd 256", 20'd256, 20'(n_rd));
    chk("rd err", 20'h0, 20'(cmd_err_code));
    chk("rd end", 20'h12A, rd_sector_lsa);
    chk("rd trk", 20'h25, drv_track);
    // recovery by retry and by correction
    rd_errs = 2'd1;
    run(OP_READ, 8'h40, 8'h2B, 8'h01, 8'h80);
    chk("retry ok", 20'h0, 20'(cmd_err_code));
    run(OP_READ, 8'h40, 8'h2B, 8'h01, 8'h00);
    chk("no retry", 20'h13, 20'(cmd_err_code));
    ecc_ok = 1'b1;
    run(OP_READ, 8'h40, 8'h2B, 8'h01, 8'h40);
    chk("ecc ok", 20'h0, 20'(cmd_err_code));
    ecc_ok = 1'b0;
    rd_errs = 2'd3;
    run(OP_READ, 8'h40, 8'h2B, 8'h01, 8'h80);
    chk("retry out", 20'h13, 20'(cmd_err_code));
    rd_errs = 2'd0;
    // failing seeks: check gives up at once, format recalibrates first
    seek_fail = 1'b1;
    run(OP_CHECK, 8'h40, 8'h2B, 8'h03, 8'h80);
    chk("chk seek", 20'h15, 20'(cmd_err_code));
    chk("chk no recal", 20'h0, 20'(n_recal - rc0));
    run(OP_FMT, 8'h40, 8'h2B, 8'h03, 8'h00);
    chk("fmt seek", 20'h15, 20'(cmd_err_code));
    chk("fmt recal", 20'h1, 20'(n_recal - rc0));
    seek_fail = 1'b0;
    // an opcode outside this block is refused
    run(8'h09, 8'h40, 8'h2B, 8'h01, 8'h00);
    chk("opcode", 20'h20, 20'(cmd_err_code));
    close_out();
  end
endmodule : dtf_cmd_engine_test

// ---- bench/dtf_drive_model.sv ----
// drive model answering seek, recalibrate, ID, format write and sector read requests
`timescale 1ns/1ps
module dtf_drive_model #(
  parameter int SPT = 8
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // requests from the engine
  input wire logic drv_seek_req,
  input wire logic drv_recal_req,
  input wire logic [19:0] drv_track,
  input wire logic drv_id_req,
  input wire logic drv_wr_req,
  input wire dtf_pkg::dtf_id_t drv_wr_id,
  input wire logic drv_rd_req,
  // bench controls
  input wire logic crc_mode,
  input wire logic [1:0] rd_errs,
  input wire logic ecc_ok,
  input wire logic seek_fail,
  // answers
  output logic drv_done,
  output logic drv_fail,
  output logic drv_id_valid,
  output logic drv_id_crc_err,
  output dtf_pkg::dtf_id_t drv_id,
  output logic drv_wr_ack,
  output logic drv_rd_done,
  output logic drv_rd_err,
  output logic drv_rd_ecc_fix,
  output int n_recal
);
  import dtf_pkg::*;
  logic [7:0] mem [SPT];
  logic [19:0] cur_q;
  logic [19:0] fmt_trk_q;
  logic [7:0] fmt_flags_q;
  logic fmt_q;
  logic slow_q;
  int wk;
  int ik;
  int dly;
  int kind;
  int errs_left;
  // seek and recalibrate fail while the bench asks for it
  assign drv_fail = seek_fail;
  // one request at a time, answered after a short or a long delay
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      {drv_done, drv_id_valid, drv_id_crc_err, drv_wr_ack, drv_rd_done, drv_rd_err, drv_rd_ecc_fix} <= '0;
      drv_id <= '0;
      {cur_q, fmt_trk_q, fmt_flags_q, fmt_q, slow_q} <= '0;
      {wk, ik, dly, kind, errs_left, n_recal} <= '0;
    end else begin
      // released strobes clear and data lines flip so that stale values are never trusted
      {drv_done, drv_wr_ack, drv_rd_done, drv_id_valid} <= '0;
      drv_id <= ~drv_id;
      drv_id_crc_err <= ~drv_id_crc_err;
      drv_rd_err <= ~drv_rd_err;
      drv_rd_ecc_fix <= ~drv_rd_ecc_fix;
      slow_q <= ~slow_q;
      if (drv_seek_req || drv_recal_req || drv_wr_req || drv_rd_req) begin
        dly <= slow_q ? 6 : 1;
        kind <= drv_wr_req ? 2 : (drv_rd_req ? 3 : 1);
        if (drv_seek_req) cur_q <= drv_track;
        if (drv_seek_req) errs_left <= int'(rd_errs);
        if (drv_recal_req) cur_q <= '0;
        if (drv_recal_req) n_recal <= n_recal + 1;
        if (drv_wr_req) begin
          // the track remembers what was written, slot by slot
          mem[wk] <= drv_wr_id.sector;
          wk <= (wk + 1) % SPT;
          fmt_trk_q <= drv_wr_id.track;
          fmt_flags_q <= drv_wr_id.flags;
          fmt_q <= 1'b1;
        end
      end else if (dly > 0) begin
        dly <= dly - 1;
      end else if (kind != 0) begin
        kind <= 0;
        drv_done <= (kind == 1);
        drv_wr_ack <= (kind == 2);
        if (kind == 3) begin
          drv_rd_done <= 1'b1;
          drv_rd_err <= (errs_left > 0);
          drv_rd_ecc_fix <= ecc_ok && (errs_left > 0);
          drv_id <= {cur_q, 8'h00, (cur_q == fmt_trk_q) ? fmt_flags_q : 8'h00};
          if (errs_left > 0) errs_left <= errs_left - 1;
        end
      end
      // IDs stream from the first sector after index while asked for
      if (!drv_id_req) begin
        ik <= 0;
      end else if (!drv_id_valid) begin
        drv_id_valid <= 1'b1;
        drv_id_crc_err <= crc_mode || !fmt_q;
        drv_id <= {cur_q, mem[ik], fmt_flags_q};
        ik <= (ik + 1) % SPT;
      end
    end
  end
endmodule : dtf_drive_model

// ---- hw/dtf_cmd_engine.sv ----
// command engine for check track, format track, format bad track and read data
`timescale 1ns/1ps
module dtf_cmd_engine #(
  parameter int SECT_BITS = 5,
  parameter int RETRY_MAX = 3
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // host command side
  input wire logic cmd_valid,
  input wire dtf_pkg::dtf_cmd_t cmd_block,
  output logic cmd_ready,
  output logic cmd_done,
  output logic [5:0] cmd_err_code,
  output logic [19:0] cmd_err_lsa,
  output logic [1:0] drive_select_field,
  // read data stream to host
  output logic rd_sector_valid,
  output logic [19:0] rd_sector_lsa,
  // drive positioning
  output logic drv_seek_req,
  output logic drv_recal_req,
  output logic [19:0] drv_track,
  input wire logic drv_done,
  input wire logic drv_fail,
  // drive ID reading
  output logic drv_id_req,
  input wire logic drv_id_valid,
  input wire logic drv_id_crc_err,
  input wire dtf_pkg::dtf_id_t drv_id,
  // drive format writing
  output logic drv_wr_req,
  output dtf_pkg::dtf_id_t drv_wr_id,
  output logic [7:0] drv_fill,
  output logic drv_fill_buf,
  input wire logic drv_wr_ack,
  // drive sector reading
  output logic drv_rd_req,
  output logic [19:0] drv_rd_lsa,
  input wire logic drv_rd_done,
  input wire logic drv_rd_err,
  input wire logic drv_rd_ecc_fix
);
  import dtf_pkg::*;
  localparam int SPT = 1 << SECT_BITS;

  dtf_state_t state_q;
  dtf_cmd_t cmd_q;
  logic [19:0] lsa_q;
  logic [19:0] trk;
  logic [8:0] cnt_q;
  logic [7:0] try_q;
  logic [SECT_BITS-1:0] idx_q;
  logic [SECT_BITS-1:0] slot_q;
  logic [8:0] sec_q;
  logic [SPT-1:0] used_q;
  logic [7:0] ilv_tbl [SPT];
  logic [4:0] ilv_eff;
  logic recal_q;
  logic pend_q;
  logic build_done;
  logic place;
  logic last_idx;

  // ****************************************
  // decoding helpers
  // ****************************************
  function automatic logic is_fmt(input logic [7:0] op);
    return (op == OP_FMT) || (op == OP_FMT_BAD);
  endfunction : is_fmt

  // only the address bits are taken; fixed-zero bits are ignored
  function automatic logic [19:0] cmd_lsa(input dtf_cmd_t c);
    return {c.ctl1[3:0], c.addr_mid, c.addr_lo};
  endfunction : cmd_lsa

  // track number drops the sector bits
  assign trk = lsa_q >> SECT_BITS;
  assign ilv_eff = (cmd_q.arg[4:0] == 5'h00) ? 5'h01 : cmd_q.arg[4:0];
  assign build_done = (sec_q == 9'(SPT));
  assign place = (state_q == ST_BUILD) && !build_done && !used_q[slot_q];
  assign last_idx = (idx_q == SECT_BITS'(SPT - 1));
  assign cmd_ready = (state_q == ST_IDLE);
  assign drv_id_req = (state_q == ST_VERIFY) || (state_q == ST_CHECK);

  // ****************************************
  // interleave table build
  // ****************************************
  // one slot probed per cycle: occupied slots are stepped over
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      slot_q <= '0;
      sec_q <= '0;
      used_q <= '0;
    end else if (state_q == ST_IDLE) begin
      slot_q <= '0;
      sec_q <= '0;
      used_q <= '0;
    end else if (place) begin
      used_q[slot_q] <= 1'b1;
      sec_q <= sec_q + 9'h001;
      slot_q <= SECT_BITS'(32'(slot_q) + 32'(ilv_eff));
    end else if ((state_q == ST_BUILD) && !build_done) begin
      slot_q <= slot_q + 1'b1;
    end
  end

  // table storage, written only while building
  always_ff @(posedge mclk) begin
    if (place) begin
      ilv_tbl[slot_q] <= sec_q[7:0];
    end
  end

  // ****************************************
  // command sequencer
  // ****************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      cmd_q <= '0;
      lsa_q <= '0;
      cnt_q <= '0;
      try_q <= '0;
      idx_q <= '0;
      recal_q <= 1'b0;
      pend_q <= 1'b0;
      cmd_done <= 1'b0;
      cmd_err_code <= ERR_NONE;
      cmd_err_lsa <= '0;
      drive_select_field <= '0;
      rd_sector_valid <= 1'b0;
      rd_sector_lsa <= '0;
      drv_seek_req <= 1'b0;
      drv_recal_req <= 1'b0;
      drv_track <= '0;
      drv_wr_req <= 1'b0;
      drv_wr_id <= '0;
      drv_fill <= FILL_DEFAULT;
      drv_fill_buf <= 1'b0;
      drv_rd_req <= 1'b0;
      drv_rd_lsa <= '0;
    end else begin
      cmd_done <= 1'b0;
      rd_sector_valid <= 1'b0;
      drv_seek_req <= 1'b0;
      drv_recal_req <= 1'b0;
      drv_wr_req <= 1'b0;
      drv_rd_req <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (cmd_valid) begin
            cmd_q <= cmd_block;
            lsa_q <= cmd_lsa(cmd_block);
            drive_select_field <= cmd_block.ctl1[DRV_HI:DRV_LO];
            cnt_q <= (cmd_block.arg == 8'h00) ? CNT_MAX : {1'b0, cmd_block.arg};
            cmd_err_code <= ERR_NONE;
            recal_q <= 1'b0;
            pend_q <= 1'b0;
            try_q <= '0;
            idx_q <= '0;
            case (cmd_block.op)
              OP_CHECK, OP_FMT, OP_FMT_BAD: state_q <= ST_BUILD;
              OP_READ: state_q <= ST_SEEK;
              default: begin
                cmd_err_code <= ERR_OPCODE;
                state_q <= ST_DONE;
              end
            endcase
          end
        end
        ST_BUILD: begin
          if (build_done) begin
            state_q <= ST_SEEK;
          end
        end
        ST_SEEK: begin
          if (!pend_q) begin
            drv_seek_req <= 1'b1;
            drv_track <= trk;
            pend_q <= 1'b1;
          end else if (drv_done) begin
            pend_q <= 1'b0;
            idx_q <= '0;
            if (drv_fail) begin
              if (is_fmt(cmd_q.op) && !recal_q) begin
                state_q <= ST_RECAL;
              end else begin
                cmd_err_code <= ERR_SEEK;
                state_q <= ST_DONE;
              end
            end else if (cmd_q.op == OP_CHECK) begin
              state_q <= ST_CHECK;
            end else if (cmd_q.op == OP_READ) begin
              state_q <= ST_RD;
            end else if (recal_q) begin
              state_q <= ST_FMT;
            end else begin
              state_q <= ST_VERIFY;
            end
          end
        end
        ST_VERIFY: begin
          if (drv_id_valid) begin
            if (!drv_id_crc_err && (drv_id.track == drv_track)) begin
              state_q <= ST_FMT;
            end else begin
              state_q <= ST_RECAL;
            end
          end
        end
        ST_RECAL: begin
          if (!pend_q) begin
            drv_recal_req <= 1'b1;
            pend_q <= 1'b1;
          end else if (drv_done) begin
            pend_q <= 1'b0;
            recal_q <= 1'b1;
            if (drv_fail) begin
              cmd_err_code <= ERR_SEEK;
              state_q <= ST_DONE;
            end else begin
              state_q <= ST_SEEK;
            end
          end
        end
        ST_CHECK: begin
          if (drv_id_valid) begin
            idx_q <= idx_q + 1'b1;
            cmd_err_lsa <= {trk[19-SECT_BITS:0], idx_q};
            if (drv_id_crc_err) begin
              cmd_err_code <= ERR_BAD_ID;
              state_q <= ST_DONE;
            end else if (drv_id.sector != ilv_tbl[idx_q]) begin
              cmd_err_code <= ERR_ILV;
              state_q <= ST_DONE;
            end else if (last_idx) begin
              cmd_err_lsa <= {trk[19-SECT_BITS:0], idx_q} + 20'h00001;
              state_q <= ST_DONE;
            end
          end
        end
        ST_FMT: begin
          if (!pend_q) begin
            drv_wr_req <= 1'b1;
            drv_wr_id.track <= trk;
            drv_wr_id.sector <= ilv_tbl[idx_q];
            drv_wr_id.flags <= FLAGS_RST;
            drv_wr_id.flags[BAD_FLAG_BIT] <= (cmd_q.op == OP_FMT_BAD);
            drv_fill <= FILL_DEFAULT;
            drv_fill_buf <= cmd_q.opt[PAT_BIT];
            pend_q <= 1'b1;
          end else if (drv_wr_ack) begin
            pend_q <= 1'b0;
            idx_q <= idx_q + 1'b1;
            cmd_err_lsa <= {trk[19-SECT_BITS:0], idx_q} + 20'h00001;
            if (last_idx) begin
              state_q <= ST_DONE;
            end
          end
        end
        ST_RD: begin
          if (!pend_q) begin
            drv_rd_req <= 1'b1;
            drv_rd_lsa <= lsa_q;
            pend_q <= 1'b1;
          end else if (drv_rd_done) begin
            pend_q <= 1'b0;
            cmd_err_lsa <= lsa_q;
            if (drv_id.flags[BAD_FLAG_BIT]) begin
              cmd_err_code <= ERR_BAD_TRACK;
              state_q <= ST_DONE;
            end else if (drv_rd_err && !(drv_rd_ecc_fix && cmd_q.opt[ECC_BIT])) begin
              if (cmd_q.opt[RETRY_BIT] && (try_q < 8'(RETRY_MAX))) begin
                try_q <= try_q + 8'h01;
              end else begin
                cmd_err_code <= ERR_READ;
                state_q <= ST_DONE;
              end
            end else begin
              try_q <= '0;
              rd_sector_valid <= 1'b1;
              rd_sector_lsa <= lsa_q;
              lsa_q <= lsa_q + 20'h00001;
              cnt_q <= cnt_q - 9'h001;
              if (cnt_q == 9'h001) begin
                state_q <= ST_DONE;
              end else if (lsa_q[SECT_BITS-1:0] == SECT_BITS'(SPT - 1)) begin
                state_q <= ST_SEEK;
              end
            end
          end
        end
        ST_DONE: begin
          cmd_done <= 1'b1;
          state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking dtf_cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  fill_select_a: assert property (drv_wr_req |-> drv_fill == FILL_DEFAULT && drv_fill_buf == cmd_q.opt[PAT_BIT])
    else $error("fill source does not follow pattern bit");
  bad_flag_a: assert property (drv_wr_req |-> drv_wr_id.flags[BAD_FLAG_BIT] == (cmd_q.op == OP_FMT_BAD))
    else $error("bad track flag wrong in written ID");
  bad_track_a: assert property ((state_q == ST_RD) && pend_q && drv_rd_done && drv_id.flags[BAD_FLAG_BIT]
    |=> cmd_err_code == ERR_BAD_TRACK ##1 cmd_done)
    else $error("flagged track not refused with code 19");
  no_recal_check_a: assert property ((cmd_q.op == OP_CHECK) && (state_q != ST_IDLE) |-> !drv_recal_req)
    else $error("recalibration during track check");
  read_count_a: assert property (cmd_ready && cmd_valid && cmd_block.op == OP_READ && cmd_block.arg == 8'h00
    |=> cnt_q == CNT_MAX)
    else $error("zero count not taken as 256");
  seek_track_a: assert property (drv_seek_req |-> drv_track == (lsa_q >> SECT_BITS))
    else $error("seek not aimed at track of address");
  ilv_err_a: assert property ((state_q == ST_CHECK) && drv_id_valid && !drv_id_crc_err
    && drv_id.sector != ilv_tbl[idx_q] |=> cmd_err_code == ERR_ILV && state_q == ST_DONE)
    else $error("interleave mismatch not reported");
  verify_fail_a: assert property ((state_q == ST_VERIFY) && drv_id_valid && drv_id_crc_err
    |=> state_q == ST_RECAL ##1 drv_recal_req)
    else $error("failed verify did not recalibrate");
  table_order_a: assert property (drv_wr_req |-> drv_wr_id.sector == ilv_tbl[$past(idx_q)])
    else $error("written sector not from interleave table");
endmodule : dtf_cmd_engine

// ---- hw/dtf_pkg.sv ----
// constants and types for the track format / read command engine
// Summary of operation
// - check track builds an interleave table of expected sector numbers first
// - check track seeks to the target track without recalibrating
// - track check flags bad ID fields and compares each sector with the table
// - track check reads IDs from the first sector after index, skipping data
// - a sector number differing from the table reports a check track error
// - check track block: opcode 05, drive select, address, interleave, retry bit; the engine never reads the retry bit for check track
// - format track, opcode 06, formats the track holding the given address
// - format seeks, verifies by ID; on failure recalibrates, reseeks, then formats
// - an unformatted drive is recalibrated, reseeked and formatted
// - ID and data fields are written in interleave order from byte 4
// - a normal format clears defective and alternate track flags
// - pattern bit 0 fills with 6C, 1 takes the pattern from buffer
// - format bad track, opcode 07, also sets ID flag bit 1
// - a later read of a flagged track is refused with error 19
// - read data, opcode 08, moves byte 4 sectors from address in bytes 1-3
// - read moves 1 to 256 sectors; count zero means 256
// - read errors are recovered as the byte 5 option bits select
// - read byte 5 bit 7 enables retries, bit 6 enables correction
// - every format starts at the first sector of the addressed track
package dtf_pkg;
  // ****************************************
  // opcodes, fill and error codes
  // ****************************************
  localparam logic [7:0] OP_CHECK = 8'h05;
  localparam logic [7:0] OP_FMT = 8'h06;
  localparam logic [7:0] OP_FMT_BAD = 8'h07;
  localparam logic [7:0] OP_READ = 8'h08;
  localparam logic [7:0] FILL_DEFAULT = 8'h6C;
  localparam logic [5:0] ERR_NONE = 6'h00;
  localparam logic [5:0] ERR_BAD_TRACK = 6'h19;
  localparam logic [5:0] ERR_BAD_ID = 6'h11;
  localparam logic [5:0] ERR_ILV = 6'h12;
  localparam logic [5:0] ERR_READ = 6'h13;
  localparam logic [5:0] ERR_SEEK = 6'h15;
  localparam logic [5:0] ERR_OPCODE = 6'h20;
  // ****************************************
  // field positions and counts
  // ****************************************
  localparam int DRV_HI = 6;
  localparam int DRV_LO = 5;
  localparam int RETRY_BIT = 7;
  localparam int ECC_BIT = 6;
  localparam int PAT_BIT = 5;
  localparam int BAD_FLAG_BIT = 1;
  localparam logic [8:0] CNT_MAX = 9'h100;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  // ****************************************
  // types
  // ****************************************
  typedef struct packed {
    logic [7:0] op;
    logic [7:0] ctl1;
    logic [7:0] addr_mid;
    logic [7:0] addr_lo;
    logic [7:0] arg;
    logic [7:0] opt;
  } dtf_cmd_t;
  typedef struct packed {
    logic [19:0] track;
    logic [7:0] sector;
    logic [7:0] flags;
  } dtf_id_t;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_BUILD = 4'b0001,
    ST_SEEK = 4'b0010,
    ST_RECAL = 4'b0011,
    ST_VERIFY = 4'b0100,
    ST_CHECK = 4'b0101,
    ST_FMT = 4'b0110,
    ST_RD = 4'b0111,
    ST_DONE = 4'b1000
  } dtf_state_t;
endpackage : dtf_pkg
